// ### design/amf_pkg.sv
package amf_pkg;
   // message type codes
   localparam logic [7:0]  ASSIGN_TYPE_CODE = 8'h01;
   localparam logic [7:0]  ACK_TYPE_CODE    = 8'h02;
   localparam logic [7:0]  QUERY_TYPE_CODE  = 8'h03;
   localparam logic [7:0]  REPLY_TYPE_CODE  = 8'h04;
   // session-state record
   localparam logic [7:0]  RECORD_TYPE_CODE = 8'h01;
   localparam logic [7:0]  RECORD_OCTETS    = 8'h13; // 19 octets, all but the length octet
   localparam logic [15:0] DEFAULT_SUBTYPE  = 16'h0000;
   // identity type codes
   localparam logic [23:0] ID_EUI48 = 24'h300000;
   localparam logic [23:0] ID_EUI64 = 24'h400000;
   localparam logic [23:0] ID_ESN   = 24'h100000;
   localparam logic [23:0] ID_NULL  = 24'hffffff;
   localparam logic [7:0]  ID_KIND_HI = 8'h00;
   // message lengths in octets
   localparam logic [5:0]  ASSIGN_OCTETS = 6'd23;
   localparam logic [5:0]  RECORD_TOTAL  = 6'd20;
   localparam logic [5:0]  QUERY_OCTETS  = 6'd2;
   // protocol timers
   localparam int unsigned CLOCK_HZ            = 20_000_000;
   localparam int unsigned ASSIGN_WAIT_SEC     = 120;
   localparam int unsigned DUAL_ADDR_SEC       = 180;
   localparam longint unsigned ASSIGN_WAIT_CYCLES =
      longint'(ASSIGN_WAIT_SEC) * longint'(CLOCK_HZ);
   localparam longint unsigned DUAL_ADDR_CYCLES =
      longint'(DUAL_ADDR_SEC) * longint'(CLOCK_HZ);
   // number of terminals tracked
   localparam int unsigned TERM_COUNT = 16;
   localparam int unsigned TERM_W     = 4;
   typedef enum logic [1:0] {
      AMF_TX_IDLE   = 2'b00,
      AMF_TX_ASSIGN = 2'b01,
      AMF_TX_RECORD = 2'b11,
      AMF_TX_QUERY  = 2'b10
   } amf_tx_e;
   typedef enum logic [2:0] {
      AMF_RX_TYPE  = 3'b000,
      AMF_RX_SEQ   = 3'b001,
      AMF_RX_ID    = 3'b011,
      AMF_RX_LEN   = 3'b010,
      AMF_RX_VALUE = 3'b110
   } amf_rx_e;
   // octet k (msb first) of a big-endian frame image
   function automatic logic [7:0] pick(input logic [183:0] img,
                                       input logic [5:0]   k);
      pick = img[183 - 8*k -: 8];
   endfunction
   // only the listed codes and the registered-kind range are valid
   function automatic logic type_ok(input logic [23:0] t);
      type_ok = (t == ID_EUI48) || (t == ID_EUI64) || (t == ID_ESN)
             || (t == ID_NULL) || (t[23:16] == ID_KIND_HI);
   endfunction
endpackage

// ### design/amf_framer.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// - assign message: id, seq, mask, seed, identifier
// - assign message type code is 0x01
// - per-terminal sequence increments modulo 256
// - first assignment per terminal uses zero
// - mask field holds subnet ones count
// - seed field from terminal session seed
// - identifier field holds assigned identifier
// - query is type 0x03 then transaction
// - identity type codes and invalid set
// - assignment wait timeout is 120 seconds; only ASSIGN_WAIT_CYCLES is defined, no timer runs
// - default protocol subtype is 0x0000
// - record: type 0x01, length, seq, subnet, id
// - record length excludes length octet
// - record sequence is last sent sequence
// - record subnet and identifier from assignment
module amf_framer (
   input  wire logic                       i_clock,
   input  wire logic                       i_reset,
   input  wire logic                       i_enable,
   input  wire logic                       i_assign_req,
   input  wire logic [amf_pkg::TERM_W-1:0] i_term,
   input  wire logic [7:0]                 i_subnet_ones_count,
   input  wire logic [31:0]                i_session_seed_value,
   input  wire logic [127:0]               i_unicast_terminal_id,
   input  wire logic                       i_record_req,
   input  wire logic                       i_query_req,
   input  wire logic [7:0]                 i_transaction_num,
   input  wire logic                       i_tx_ready,
   input  wire logic                       i_rx_valid,
   input  wire logic [7:0]                 i_rx_data,
   input  wire logic                       i_rx_last,
   output logic                            o_busy,
   output logic                            o_tx_valid,
   output logic [7:0]                      o_tx_data,
   output logic                            o_tx_last,
   output logic                            o_ack_match,
   output logic                            o_reply_done,
   output logic [23:0]                     o_identity_type_code,
   output logic [7:0]                      o_identity_value_octets,
   output logic                            o_reply_error,
   output logic [15:0]                     o_default_subtype
);
   import amf_pkg::*;
   // ------------------------------------------------------------
   // transmit side
   // ------------------------------------------------------------
   amf_tx_e        tx_state_q;
   logic [183:0]   img_q;
   logic [5:0]     idx_q;
   logic [5:0]     len_q;
   logic [7:0]     seq_q  [TERM_COUNT];
   logic [7:0]     last_seq_q [TERM_COUNT];
   logic [7:0]     last_mask_q [TERM_COUNT];
   logic [127:0]   last_id_q [TERM_COUNT];
   logic [TERM_W-1:0] pend_term_q;
   logic           pend_q;
   wire logic [7:0]   cur_seq    = seq_q[i_term];
   wire logic         tx_idle    = (tx_state_q == AMF_TX_IDLE);
   wire logic         tx_fire    = o_tx_valid && i_tx_ready;
   wire logic         tx_end     = tx_fire && o_tx_last;
   wire logic [5:0]   idx_nxt    = idx_q + 6'd1;
   wire logic         start_asg  = tx_idle && i_assign_req;
   wire logic         start_rec  = tx_idle && !i_assign_req && i_record_req;
   wire logic         start_qry  = tx_idle && !i_assign_req
                                   && !i_record_req && i_query_req;
   // assignment frame image, fields packed msb first, no padding
   wire logic [183:0] asg_img = {ASSIGN_TYPE_CODE,
                                 cur_seq,
                                 i_subnet_ones_count,
                                 i_session_seed_value,
                                 i_unicast_terminal_id};
   // record image built from what was last sent to this terminal
   wire logic [183:0] rec_img = {RECORD_TYPE_CODE,
                                 RECORD_OCTETS,
                                 last_seq_q[i_term],
                                 last_mask_q[i_term],
                                 last_id_q[i_term],
                                 24'h000000};
   wire logic [183:0] qry_img = {QUERY_TYPE_CODE, i_transaction_num,
                                 168'h0};
   // frame sequencer; one octet per accepted beat
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         tx_state_q <= AMF_TX_IDLE;
         img_q      <= 184'h0;
         idx_q      <= 6'd0;
         len_q      <= 6'd0;
         o_tx_valid <= 1'b0;
         o_tx_data  <= 8'h00;
         o_tx_last  <= 1'b0;
         o_busy     <= 1'b0;
      end else if (i_enable) begin
         if (start_asg || start_rec || start_qry) begin
            tx_state_q <= start_asg ? AMF_TX_ASSIGN :
                          start_rec ? AMF_TX_RECORD : AMF_TX_QUERY;
            img_q      <= start_asg ? asg_img : start_rec ? rec_img
                                                          : qry_img;
            len_q      <= start_asg ? ASSIGN_OCTETS :
                          start_rec ? RECORD_TOTAL : QUERY_OCTETS;
            idx_q      <= 6'd0;
            o_tx_valid <= 1'b1;
            o_tx_data  <= start_asg ? ASSIGN_TYPE_CODE :
                          start_rec ? RECORD_TYPE_CODE : QUERY_TYPE_CODE;
            o_tx_last  <= 1'b0;
            o_busy     <= 1'b1;
         end else if (tx_end) begin
            tx_state_q <= AMF_TX_IDLE;
            o_tx_valid <= 1'b0;
            o_tx_last  <= 1'b0;
            o_busy     <= 1'b0;
         end else if (tx_fire) begin
            idx_q     <= idx_nxt;
            o_tx_data <= pick(img_q, idx_nxt);
            o_tx_last <= (idx_nxt == len_q - 6'd1);
         end
      end
   end
   // per-terminal sequence and last-assignment memory
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         pend_q      <= 1'b0;
         pend_term_q <= '0;
         for (int t = 0; t < TERM_COUNT; t++) begin
            seq_q[t]       <= 8'h00;
            last_seq_q[t]  <= 8'h00;
            last_mask_q[t] <= 8'h00;
            last_id_q[t]   <= 128'h0;
         end
      end else if (i_enable) begin
         if (start_asg) begin
            seq_q[i_term]       <= cur_seq + 8'h01;
            last_seq_q[i_term]  <= cur_seq;
            last_mask_q[i_term] <= i_subnet_ones_count;
            last_id_q[i_term]   <= i_unicast_terminal_id;
            pend_q              <= 1'b1;
            pend_term_q         <= i_term;
         end else if (o_ack_match)
            pend_q <= 1'b0;
      end
   end
   // ------------------------------------------------------------
   // receive side: ack and identity reply parser
   // ------------------------------------------------------------
   amf_rx_e     rx_state_q;
   logic [7:0]  rx_code_q;
   logic [7:0]  rx_txn_q;
   logic [1:0]  rx_cnt_q;
   logic [7:0]  rx_left_q;
   logic [7:0]  qry_txn_q;
   wire logic [23:0] rx_type = {o_identity_type_code[15:0], i_rx_data};
   wire logic        is_ack  = (rx_code_q == ACK_TYPE_CODE);
   // ack must echo the sequence of the last assignment sent
   wire logic ack_hit = pend_q && is_ack
                        && (i_rx_data == last_seq_q[pend_term_q]);
   // query transaction kept to pair the reply
   always_ff @(posedge i_clock) begin
      if (i_reset)
         qry_txn_q <= 8'h00;
      else if (i_enable && start_qry)
         qry_txn_q <= i_transaction_num;
   end
   // byte parser; the value octets are counted and discarded
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         rx_state_q              <= AMF_RX_TYPE;
         rx_code_q               <= 8'h00;
         rx_txn_q                <= 8'h00;
         rx_cnt_q                <= 2'd0;
         rx_left_q               <= 8'h00;
         o_ack_match             <= 1'b0;
         o_reply_done            <= 1'b0;
         o_reply_error           <= 1'b0;
         o_identity_type_code    <= 24'h0;
         o_identity_value_octets <= 8'h00;
         o_default_subtype       <= DEFAULT_SUBTYPE;
      end else if (i_enable) begin
         o_ack_match   <= 1'b0;
         o_reply_done  <= 1'b0;
         o_reply_error <= 1'b0;
         if (i_rx_valid) begin
            case (rx_state_q)
               AMF_RX_TYPE: begin
                  rx_code_q  <= i_rx_data;
                  rx_state_q <= (i_rx_last) ? AMF_RX_TYPE : AMF_RX_SEQ;
               end
               AMF_RX_SEQ: begin
                  rx_txn_q   <= i_rx_data;
                  rx_cnt_q   <= 2'd0;
                  o_ack_match <= ack_hit;
                  rx_state_q <= (rx_code_q == REPLY_TYPE_CODE
                                 && !i_rx_last) ? AMF_RX_ID : AMF_RX_TYPE;
               end
               AMF_RX_ID: begin
                  o_identity_type_code <= rx_type;
                  rx_cnt_q             <= rx_cnt_q + 2'd1;
                  if (rx_cnt_q == 2'd2)
                     rx_state_q <= AMF_RX_LEN;
               end
               AMF_RX_LEN: begin
                  o_identity_value_octets <= i_rx_data;
                  rx_left_q               <= i_rx_data;
                  if (i_rx_last || i_rx_data == 8'h00) begin
                     o_reply_done  <= 1'b1;
                     // a frame cut at a non-zero length is short too
                     o_reply_error <= !type_ok(o_identity_type_code)
                        || (rx_txn_q != qry_txn_q)
                        || (o_identity_type_code != ID_NULL)
                        || (i_rx_data != 8'h00);
                     rx_state_q    <= AMF_RX_TYPE;
                  end else
                     rx_state_q <= AMF_RX_VALUE;
               end
               AMF_RX_VALUE: begin
                  rx_left_q <= rx_left_q - 8'h01;
                  if (i_rx_last || rx_left_q == 8'h01) begin
                     o_reply_done  <= 1'b1;
                     o_reply_error <= !type_ok(o_identity_type_code)
                        || (rx_txn_q != qry_txn_q)
                        || (o_identity_type_code == ID_NULL)
                        || (rx_left_q != 8'h01);
                     rx_state_q    <= AMF_RX_TYPE;
                  end
               end
               default: rx_state_q <= AMF_RX_TYPE;
            endcase
         end
      end
   end
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   sequence s_asg_start;
      i_enable && start_asg;
   endsequence
   property p_asg_code;
      @(posedge i_clock) disable iff (i_reset)
      s_asg_start |=> (o_tx_valid && o_tx_data == 8'h01);
   endproperty
   a_asg_code: assert property (p_asg_code)
      else $error("assign frame does not start with 0x01");
   property p_seq_step;
      @(posedge i_clock) disable iff (i_reset)
      s_asg_start |=> (seq_q[$past(i_term)] ==
                       8'($past(cur_seq) + 8'h01));
   endproperty
   a_seq_step: assert property (p_seq_step)
      else $error("sequence did not advance by one");
   property p_len_asg;
      @(posedge i_clock) disable iff (i_reset)
      s_asg_start |=> (len_q == 6'd23);
   endproperty
   a_len_asg: assert property (p_len_asg)
      else $error("assign frame length not 23 octets");
   property p_rec_len;
      @(posedge i_clock) disable iff (i_reset)
      (i_enable && start_rec) |=> (img_q[175:168] == 8'd19);
   endproperty
   a_rec_len: assert property (p_rec_len)
      else $error("record length field wrong");
   property p_ack_pair;
      @(posedge i_clock) disable iff (i_reset)
      o_ack_match |-> $past(is_ack);
   endproperty
   a_ack_pair: assert property (p_ack_pair)
      else $error("ack match without ack code");
   property p_err_only_done;
      @(posedge i_clock) disable iff (i_reset)
      o_reply_error |-> o_reply_done;
   endproperty
   a_err_only_done: assert property (p_err_only_done)
      else $error("reply error without reply end");
   property p_subtype;
      @(posedge i_clock) disable iff (i_reset)
      o_default_subtype == 16'h0000;
   endproperty
   a_subtype: assert property (p_subtype)
      else $error("default subtype not zero");
   property p_last_hold;
      @(posedge i_clock) disable iff (i_reset)
      (o_tx_valid && !i_tx_ready && i_enable)
         |=> (o_tx_valid && $stable(o_tx_data));
   endproperty
   a_last_hold: assert property (p_last_hold)
      else $error("tx octet changed while stalled");
endmodule
`default_nettype wire

// ### test/amf_term_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// terminal side of the signalling link
// ----------------------------------------
module amf_term_model (
   input  wire logic       i_clock,
   output logic            o_tx_ready,
   output logic [7:0]      o_rx_data,
   output logic            o_rx_valid,
   output logic            o_rx_last
);
   logic stall_on = 1'b1;
   initial begin
      o_tx_ready = 1'b0;
      o_rx_data = 8'h00;
      o_rx_valid = 1'b0;
      o_rx_last = 1'b0;
   end
   // random sink stalls, so octets must stand until taken
   always @(posedge i_clock) begin
      #1 o_tx_ready = stall_on ? 1'($urandom_range(1)) : 1'b1;
   end
   // one octet per cycle; released data shows its inverse
   task automatic send(input logic [7:0] q[$]);
      foreach (q[k]) begin
         @(posedge i_clock);
         #1 o_rx_valid = 1'b1;
         o_rx_data = q[k];
         o_rx_last = (k == q.size() - 1);
      end
      @(posedge i_clock);
      #1 o_rx_valid = 1'b0;
      o_rx_last = 1'b0;
      o_rx_data = ~o_rx_data;
   endtask
   task automatic send_ack(input logic [7:0] seq);
      send('{8'h02, seq});
   endtask
   task automatic send_reply(input logic [7:0] txn, input logic [23:0] code,
                             input logic [7:0] len);
      logic [7:0] q[$];
      q = '{8'h04, txn, code[23:16], code[15:8], code[7:0], len};
      repeat (len) q.push_back(8'($urandom));
      send(q);
   endtask
endmodule
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   import amf_pkg::*;
   logic clock = 1'b0, reset = 1'b1, enable = 1'b1;
   logic assign_req = 1'b0, record_req = 1'b0, query_req = 1'b0;
   logic [3:0] term = 4'h0;
   logic [7:0] mask = 8'h00, txn = 8'h00, rx_data, o_tx_data, o_octets;
   logic [31:0] seed = 32'h0;
   logic [127:0] uid = 128'h0;
   logic tx_ready, rx_valid, rx_last, o_busy, o_tx_valid, o_tx_last;
   logic o_ack_match, o_reply_done, o_reply_error;
   logic [23:0] o_code;
   logic [15:0] o_subtype;
   logic [8:0] tx_q[$];
   logic [32:0] rep_q[$];
   logic [7:0] seq_n[16], last_seq[16], mask_r[16];
   logic [127:0] id_r[16];
   int fail_count = 0, compares = 0, ack_seen = 0;
   always #25 clock = ~clock;
   amf_framer amf_framer_inst (.i_clock(clock), .i_reset(reset),
      .i_enable(enable), .i_assign_req(assign_req), .i_term(term),
      .i_subnet_ones_count(mask), .i_session_seed_value(seed),
      .i_unicast_terminal_id(uid), .i_record_req(record_req),
      .i_query_req(query_req), .i_transaction_num(txn),
      .i_tx_ready(tx_ready), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
      .i_rx_last(rx_last), .o_busy(o_busy), .o_tx_valid(o_tx_valid),
      .o_tx_data(o_tx_data), .o_tx_last(o_tx_last),
      .o_ack_match(o_ack_match), .o_reply_done(o_reply_done),
      .o_identity_type_code(o_code), .o_identity_value_octets(o_octets),
      .o_reply_error(o_reply_error), .o_default_subtype(o_subtype));
   amf_term_model amf_term_model_inst (.i_clock(clock),
      .o_tx_ready(tx_ready), .o_rx_data(rx_data), .o_rx_valid(rx_valid),
      .o_rx_last(rx_last));
   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // ----------------------------------------
   // output watchers: oldest note against each result
   // ----------------------------------------
   always @(posedge clock) begin
      if (!reset && enable && o_tx_valid === 1'b1 && tx_ready) begin
         if (tx_q.size() == 0) check(1, 0);
         else check({o_tx_last, o_tx_data}, tx_q.pop_front());
      end
      if (!reset && o_reply_done === 1'b1) begin
         if (rep_q.size() == 0) check(1, 0);
         else check({o_code, o_octets, o_reply_error}, rep_q.pop_front());
      end
      if (o_ack_match === 1'b1) ack_seen++;
   end
   // bounded wait; entered and left just after an edge
   task automatic wait_idle();
      int n;
      n = 0;
      while ((o_busy !== 1'b0 || o_tx_valid !== 1'b0 || rep_q.size() != 0)
             && n < 3000) begin
         @(posedge clock);
         #1 n++;
      end
      if (n >= 3000) begin
         fail_count++;
         print_verdict();
      end
   endtask
   task automatic push(input logic [127:0] v, input int n, input logic fin);
      for (int k = n - 1; k >= 0; k--) tx_q.push_back({fin && k == 0, v[8*k+:8]});
   endtask
   // a held request is dropped once taken; busy must show it was
   task automatic launch(input int kind, input int freeze);
      assign_req = (kind == 0);
      record_req = (kind == 1);
      query_req = (kind == 2);
      @(posedge clock);
      #1 {assign_req, record_req, query_req} = 3'b000;
      check(o_busy, 1'b1);
      if (freeze) begin
         enable = 1'b0;
         repeat (3) @(posedge clock);
         #1 enable = 1'b1;
      end
      wait_idle();
   endtask
   task automatic do_assign(input logic [3:0] t, input int freeze);
      term = t;
      mask = 8'($urandom_range(128));
      seed = $urandom;
      uid = {$urandom, $urandom, $urandom, $urandom};
      {mask_r[t], id_r[t], last_seq[t]} = {mask, uid, seq_n[t]};
      push(ASSIGN_TYPE_CODE, 1, 0);
      push(seq_n[t], 1, 0);
      push(mask, 1, 0);
      push(seed, 4, 0);
      push(uid, 16, 1);
      seq_n[t] = seq_n[t] + 8'h01;
      launch(0, freeze);
   endtask
   logic [23:0] codes[8] = '{24'h300000, 24'h400000, 24'h100000,
      24'h00abcd, 24'hffffff, 24'h200000, 24'h0a0000, 24'h300000};
   logic [7:0] lens[8] = '{8'h06, 8'h08, 8'h04, 8'h03, 8'h00, 8'h02,
      8'h01, 8'h06};
   initial begin
      void'($urandom(72));
      foreach (seq_n[k]) seq_n[k] = 8'h00;
      repeat (12) @(posedge clock);
      #1 reset = 1'b0;
      check(o_subtype, 16'h0000);
      // timer constants taken at 50 ns per cycle; only the values are checked, no timer runs
      check(ASSIGN_WAIT_CYCLES, 128'd2400000000);
      check(DUAL_ADDR_CYCLES, 128'd3600000000);
      // wrap of one terminal's count, another terminal starts at zero
      for (int k = 0; k < 257; k++) do_assign(4'h9, k == 5);
      do_assign(4'h3, 0);
      $display("test assign sequence done");
      term = 4'h9;
      mask = mask_r[9];
      uid = id_r[9];
      push(128'h01, 1, 0);
      push(128'h13, 1, 0);
      push(last_seq[9], 1, 0);
      push(mask_r[9], 1, 0);
      push(id_r[9], 16, 1);
      launch(1, 0);
      $display("test record done");
      do_assign(4'h3, 0);
      amf_term_model_inst.send_ack(last_seq[3] + 8'h01);
      amf_term_model_inst.send_ack(last_seq[3]);
      amf_term_model_inst.send_ack(last_seq[3]);
      repeat (4) @(posedge clock);
      check(ack_seen, 1);
      $display("test ack done");
      txn = 8'($urandom);
      push(128'h03, 1, 0);
      push(txn, 1, 1);
      launch(2, 0);
      foreach (codes[k]) begin
         rep_q.push_back({codes[k], lens[k], 1'(k >= 5)});
         amf_term_model_inst.send_reply(k == 7 ? ~txn : txn, codes[k], lens[k]);
         wait_idle();
      end
      $display("test identity reply done");
      check(tx_q.size(), 0);
      print_verdict();
   end
endmodule
`default_nettype wire
